//--- include/tcm_map_map.svh
// Constants for the lock-step TCM map block: address bases, sizes, ECC widths.
// Assumes inclusion by the package and by the design files by bare name.
`ifndef TCM_MAP_MAP_SVH
`define TCM_MAP_MAP_SVH
`define LOC_RAM1_BASE 32'h0000_0000
`define LOC_RAM2_BASE 32'h0002_0000
`define GLB_C0_RAM1_BASE 32'hFFE0_0000
`define GLB_C0_RAM2_BASE 32'hFFE2_0000
`define GLB_C0_ICACHE_BASE 32'hFFE4_0000
`define GLB_C0_DCACHE_BASE 32'hFFE5_0000
`define GLB_C1_RAM1_BASE 32'hFFE9_0000
`define GLB_C1_RAM2_BASE 32'hFFEB_0000
`define GLB_C1_ICACHE_BASE 32'hFFEC_0000
`define GLB_C1_DCACHE_BASE 32'hFFED_0000
`define SPLIT_RAM_BYTES 32'h0001_0000
`define LOCK_RAM_BYTES 32'h0002_0000
`define CACHE_WIN_BYTES 32'h0001_0000
`define ECC_DATA_W 32
`define ECC_CHECK_W 7
`define MODE_SPLIT_RESET 1'b1
`endif

//--- include/tcm_map_pkg.sv
// Types shared by the TCM map block, its checker and its bench.
// Assumes tcm_map_map.svh is on the include path.
`include "tcm_map_map.svh"
package tcm_map_pkg;
  // =====================================================================
  // Target selection
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_RAM1,
    TGT_RAM2,
    TGT_ICACHE,
    TGT_DCACHE
  } target_t;
  // =====================================================================
  // Request and answer carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } req_t;
  typedef struct packed {
    logic valid;
    logic error;
    logic [31:0] rdata;
  } rsp_t;
  typedef struct packed {
    logic hit;
    logic core;
    target_t tgt;
    logic [16:0] offset;
  } decode_t;
endpackage : tcm_map_pkg

//--- hw/secded_codec.sv
// SEC-DED Hamming codec over one 32-bit data chunk with 7 check bits.
// Combinational; the caller registers what it needs.
`include "tcm_map_map.svh"
module secded_codec #(
  parameter int DATA_W = `ECC_DATA_W,
  parameter int CHECK_W = `ECC_CHECK_W
) (
  // Encode side
  input wire logic [DATA_W-1:0] enc_data_in,
  output logic [CHECK_W-1:0] enc_check_out,
  // Decode side
  input wire logic [DATA_W-1:0] dec_data_in,
  input wire logic [CHECK_W-1:0] dec_check_in,
  output logic [DATA_W-1:0] dec_data_out,
  output logic dec_single_out,
  output logic dec_double_out
);
  // =====================================================================
  // Code construction
  // Data bits occupy the non-power-of-two positions of a 38-bit word;
  // check bit 6 is overall parity, which separates single from double errors.
  function automatic logic [37:0] spread(input logic [DATA_W-1:0] d);
    logic [37:0] w;
    int k;
    w = '0;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        w[p-1] = d[k];
        k++;
      end
    end
    return w;
  endfunction : spread

  function automatic logic [5:0] syndrome(input logic [37:0] w);
    logic [5:0] s;
    s = '0;
    for (int p = 1; p < 39; p++) begin
      if (w[p-1]) begin
        s = s ^ 6'(p);
      end
    end
    return s;
  endfunction : syndrome

  logic [37:0] enc_w;
  logic [37:0] dec_w;
  logic [5:0] syn;
  logic par;

  always_comb begin
    enc_w = spread(enc_data_in);
    enc_check_out = {^enc_w ^ ^syndrome(enc_w), syndrome(enc_w)};
  end

  always_comb begin
    dec_w = spread(dec_data_in);
    for (int i = 0; i < 6; i++) begin
      dec_w[(1 << i) - 1] = dec_check_in[i];
    end
    syn = syndrome(dec_w);
    par = ^dec_w ^ dec_check_in[6];
    dec_single_out = (syn != 6'h00 || par) && par;
    dec_double_out = (syn != 6'h00) && !par;
    if (par && syn != 6'h00 && syn < 6'h27) begin
      dec_w[syn-1] = ~dec_w[syn-1];
    end
    dec_data_out = '0;
    begin : gather
      int k;
      k = 0;
      for (int p = 1; p < 39; p++) begin
        if ((p & (p - 1)) != 0) begin
          dec_data_out[k] = dec_w[p-1];
          k++;
        end
      end
    end
  end
endmodule : secded_codec

//--- hw/lockstep_tcm_map.sv
// Mode control, address decode and ECC-protected local RAMs for a
// dual real-time core group. Assumes core requests are synchronous to
// sys_clk_in; mode straps arrive from pins and are synchronised here.
`include "tcm_map_map.svh"
module lockstep_tcm_map #(
  parameter int RAM_WORDS = 32768
) (
  // Clock and power-on reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Mode straps
  input wire logic output_clamp_ctrl_in,
  input wire logic split_mode_select_in,
  // Per-core resets
  input wire logic core_zero_reset_in,
  input wire logic core_one_reset_in,
  // Core local ports
  input wire tcm_map_pkg::req_t core_zero_req_in,
  input wire tcm_map_pkg::req_t core_one_req_in,
  output tcm_map_pkg::rsp_t core_zero_rsp_out,
  output tcm_map_pkg::rsp_t core_one_rsp_out,
  // Global port from the interconnect
  input wire tcm_map_pkg::req_t global_req_in,
  input wire logic global_is_core_in,
  input wire logic peripheral_guard_permit_in,
  output tcm_map_pkg::rsp_t global_rsp_out,
  // Status
  output logic lockstep_out,
  output logic clamp_out,
  output logic core_zero_in_reset_out,
  output logic core_one_in_reset_out,
  output logic ecc_corrected_out,
  output logic ecc_fatal_out
);
  // =====================================================================
  // State
  typedef struct packed {
    logic [1:0] clamp_sync;
    logic [1:0] split_sync;
    logic [1:0] rst0_sync;
    logic [1:0] rst1_sync;
    logic split;
    logic clamp;
    logic rst0;
    logic rst1;
    tcm_map_pkg::rsp_t rsp0;
    tcm_map_pkg::rsp_t rsp1;
    tcm_map_pkg::rsp_t rspg;
    logic corrected;
    logic fatal;
  } state_t;

  localparam int AW = $clog2(RAM_WORDS);
  localparam int CW = `ECC_CHECK_W;

  state_t s_r;
  state_t s_nxt;
  logic [31+CW:0] ram [2*RAM_WORDS];

  // =====================================================================
  // Address decode
  function automatic tcm_map_pkg::decode_t decode_global(input logic [31:0] a,
                                                         input logic split);
    tcm_map_pkg::decode_t d;
    logic [31:0] span;
    d = '0;
    span = split ? `SPLIT_RAM_BYTES : `LOCK_RAM_BYTES;
    d.offset = 17'(a[16:0]);
    if (a >= `GLB_C0_RAM1_BASE && a < `GLB_C0_RAM1_BASE + span) begin
      d.hit = 1'b1;
      d.tgt = tcm_map_pkg::TGT_RAM1;
    end else if (a >= `GLB_C0_RAM2_BASE && a < `GLB_C0_RAM2_BASE + span) begin
      d.hit = 1'b1;
      d.tgt = tcm_map_pkg::TGT_RAM2;
    end else if (a[31:16] == `GLB_C0_ICACHE_BASE >> 16) begin
      d.hit = 1'b1;
      d.tgt = tcm_map_pkg::TGT_ICACHE;
    end else if (a[31:16] == `GLB_C0_DCACHE_BASE >> 16) begin
      d.hit = 1'b1;
      d.tgt = tcm_map_pkg::TGT_DCACHE;
    end else if (a[31:16] == `GLB_C1_RAM1_BASE >> 16) begin
      d.hit = 1'b1;
      d.core = 1'b1;
      d.tgt = tcm_map_pkg::TGT_RAM1;
    end else if (a[31:16] == `GLB_C1_RAM2_BASE >> 16) begin
      d.hit = 1'b1;
      d.core = 1'b1;
      d.tgt = tcm_map_pkg::TGT_RAM2;
    end else if (a[31:16] == `GLB_C1_ICACHE_BASE >> 16) begin
      d.hit = 1'b1;
      d.core = 1'b1;
      d.tgt = tcm_map_pkg::TGT_ICACHE;
    end else if (a[31:16] == `GLB_C1_DCACHE_BASE >> 16) begin
      d.hit = 1'b1;
      d.core = 1'b1;
      d.tgt = tcm_map_pkg::TGT_DCACHE;
    end
    if (!split && d.core) begin
      d.hit = 1'b0;
    end
    return d;
  endfunction : decode_global

  function automatic tcm_map_pkg::decode_t decode_local(input logic [31:0] a,
                                                        input logic split,
                                                        input logic core);
    tcm_map_pkg::decode_t d;
    logic [31:0] span;
    d = '0;
    d.core = core;
    span = split ? `SPLIT_RAM_BYTES : `LOCK_RAM_BYTES;
    d.offset = 17'(a[16:0]);
    if (a >= `LOC_RAM1_BASE && a < `LOC_RAM1_BASE + span) begin
      d.hit = 1'b1;
      d.tgt = tcm_map_pkg::TGT_RAM1;
    end else if (a >= `LOC_RAM2_BASE && a < `LOC_RAM2_BASE + span) begin
      d.hit = 1'b1;
      d.tgt = tcm_map_pkg::TGT_RAM2;
    end
    return d;
  endfunction : decode_local

  // In split mode each core owns half of the storage per RAM; lock-step
  // pools both halves so core zero sees twice the size.
  function automatic logic [AW:0] ram_index(input tcm_map_pkg::decode_t d,
                                            input logic split);
    logic [AW-1:0] w;
    w = AW'(d.offset[16:2]);
    if (split) begin
      return {d.tgt == tcm_map_pkg::TGT_RAM2, d.core, w[AW-2:0]};
    end
    return {d.tgt == tcm_map_pkg::TGT_RAM2, w};
  endfunction : ram_index

  // =====================================================================
  // Arbitration: one port reaches the RAM per cycle, core zero first.
  tcm_map_pkg::decode_t d0;
  tcm_map_pkg::decode_t d1;
  tcm_map_pkg::decode_t dg;
  tcm_map_pkg::req_t sel_req;
  tcm_map_pkg::decode_t sel_dec;
  logic [1:0] sel_port;
  logic sel_ram;
  logic [AW:0] sel_idx;
  logic [CW-1:0] wcheck;
  logic [31+CW:0] rword;
  logic [31:0] rdata;
  logic rd_single;
  logic rd_double;
  logic core_one_live;
  logic g_ok;

  always_comb begin
    core_one_live = s_r.split && !s_r.rst1;
    d0 = decode_local(core_zero_req_in.addr, s_r.split, 1'b0);
    d1 = decode_local(core_one_req_in.addr, s_r.split, 1'b1);
    dg = decode_global(global_req_in.addr, s_r.split);
    g_ok = global_is_core_in || peripheral_guard_permit_in;
    sel_port = 2'h0;
    sel_req = '0;
    sel_dec = '0;
    if (core_zero_req_in.valid && !s_r.rst0 && d0.hit) begin
      sel_port = 2'h1;
      sel_req = core_zero_req_in;
      sel_dec = d0;
    end else if (core_one_req_in.valid && core_one_live && d1.hit) begin
      sel_port = 2'h2;
      sel_req = core_one_req_in;
      sel_dec = d1;
    end else if (global_req_in.valid && g_ok && dg.hit) begin
      sel_port = 2'h3;
      sel_req = global_req_in;
      sel_dec = dg;
    end
    sel_ram = sel_dec.tgt == tcm_map_pkg::TGT_RAM1 || sel_dec.tgt == tcm_map_pkg::TGT_RAM2;
    sel_idx = ram_index(sel_dec, s_r.split);
    rword = ram[sel_idx];
  end

  secded_codec u_codec (
    .enc_data_in(sel_req.wdata),
    .enc_check_out(wcheck),
    .dec_data_in(rword[31:0]),
    .dec_check_in(rword[31+CW:32]),
    .dec_data_out(rdata),
    .dec_single_out(rd_single),
    .dec_double_out(rd_double)
  );

  always_ff @(posedge sys_clk_in) begin
    if (sel_port != 2'h0 && sel_ram && sel_req.write) begin
      ram[sel_idx] <= {wcheck, sel_req.wdata};
    end
  end

  // =====================================================================
  // Next state
  function automatic tcm_map_pkg::rsp_t answer(input logic valid, input logic mine,
                                               input logic err,
                                               input logic [31:0] data);
    tcm_map_pkg::rsp_t r;
    r.valid = valid;
    r.error = mine ? err : 1'b1;
    r.rdata = mine ? data : 32'h0000_0000;
    return r;
  endfunction : answer

  logic acc_err;
  logic [31:0] acc_data;

  always_comb begin
    s_nxt = s_r;
    s_nxt.clamp_sync = {s_r.clamp_sync[0], output_clamp_ctrl_in};
    s_nxt.split_sync = {s_r.split_sync[0], split_mode_select_in};
    s_nxt.rst0_sync = {s_r.rst0_sync[0], core_zero_reset_in};
    s_nxt.rst1_sync = {s_r.rst1_sync[0], core_one_reset_in};
    s_nxt.rst0 = s_r.rst0_sync[1];
    s_nxt.rst1 = s_r.split ? s_r.rst1_sync[1] : s_r.rst0_sync[1];
    acc_err = !sel_req.write && sel_ram && rd_double;
    acc_data = (sel_ram && !sel_req.write) ? rdata : 32'h0000_0000;
    // Cache windows are mapped but the cache arrays live elsewhere; they read zero.
    s_nxt.rsp0 = answer(core_zero_req_in.valid && !s_r.rst0, sel_port == 2'h1,
                        acc_err, acc_data);
    s_nxt.rsp1 = answer(core_one_req_in.valid && core_one_live, sel_port == 2'h2,
                        acc_err, acc_data);
    s_nxt.rspg = answer(global_req_in.valid, sel_port == 2'h3, acc_err, acc_data);
    if (!sel_req.write && sel_ram && sel_port != 2'h0) begin
      s_nxt.corrected = s_r.corrected || rd_single;
      s_nxt.fatal = s_r.fatal || rd_double;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_r <= '0;
      s_r.rst0 <= 1'b1;
      s_r.rst1 <= 1'b1;
      // Straps are sampled only here so a live change cannot tear the pair apart.
      s_r.split <= s_r.split_sync[1];
      s_r.clamp <= s_r.clamp_sync[1];
      s_r.clamp_sync <= s_nxt.clamp_sync;
      s_r.split_sync <= s_nxt.split_sync;
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================================
  // Outputs
  always_comb begin
    core_zero_rsp_out = s_r.rsp0;
    core_one_rsp_out = s_r.rsp1;
    global_rsp_out = s_r.rspg;
    lockstep_out = !s_r.split;
    clamp_out = s_r.clamp;
    core_zero_in_reset_out = s_r.rst0;
    core_one_in_reset_out = s_r.rst1;
    ecc_corrected_out = s_r.corrected;
    ecc_fatal_out = s_r.fatal;
  end
endmodule : lockstep_tcm_map

//--- verif/lockstep_tcm_map_properties.sv
// Concurrent checks on the ports of the TCM map block.
// Assumes one clock domain and the default address map of the block.
module lockstep_tcm_map_checker (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Watched inputs
  input wire logic core_zero_reset_in,
  input wire logic core_one_reset_in,
  input wire tcm_map_pkg::req_t core_zero_req_in,
  input wire tcm_map_pkg::req_t global_req_in,
  input wire logic global_is_core_in,
  input wire logic peripheral_guard_permit_in,
  // Watched outputs
  input wire tcm_map_pkg::rsp_t core_zero_rsp_out,
  input wire tcm_map_pkg::rsp_t core_one_rsp_out,
  input wire tcm_map_pkg::rsp_t global_rsp_out,
  input wire logic lockstep_out,
  input wire logic clamp_out,
  input wire logic core_zero_in_reset_out,
  input wire logic core_one_in_reset_out,
  input wire logic ecc_fatal_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  rsp_timing_a: assert property (
    core_zero_req_in.valid && !core_zero_in_reset_out |=> core_zero_rsp_out.valid)
    else $error("core zero answer missing");
  no_idle_rsp_a: assert property (
    !global_req_in.valid |=> !global_rsp_out.valid) else $error("global answer without request");
  mode_static_a: assert property (
    !$past(reset_in) && !$past(reset_in, 2) |-> $stable(lockstep_out) && $stable(clamp_out))
    else $error("mode changed outside reset");
  hidden_core_a: assert property (
    lockstep_out |-> !core_one_rsp_out.valid) else $error("core one answered in lock-step");
  guard_deny_a: assert property (
    global_req_in.valid && !global_is_core_in && !peripheral_guard_permit_in
    |=> global_rsp_out.error) else $error("guard denial not refused");
  core_one_lock_a: assert property (
    lockstep_out && global_req_in.valid
    && global_req_in.addr[31:16] inside {16'hFFE9, 16'hFFEB, 16'hFFEC, 16'hFFED}
    |=> global_rsp_out.error) else $error("core one window answered in lock-step");
  lock_reset_a: assert property (
    lockstep_out && core_zero_reset_in [*4] |-> core_one_in_reset_out)
    else $error("core one not reset with core zero");
  split_reset_a: assert property (
    !lockstep_out && !core_one_reset_in [*5] |-> !core_one_in_reset_out)
    else $error("core one reset without its own request");
  fatal_sticky_a: assert property (
    ecc_fatal_out |=> ecc_fatal_out) else $error("fatal flag dropped");
  // ====================================================================
  // Coverage
  lock_refusal_c: cover property (lockstep_out && global_rsp_out.error);
  split_write_c: cover property (!lockstep_out && core_zero_req_in.valid
    && core_zero_req_in.write);
  own_reset_c: cover property (core_one_in_reset_out && !core_zero_in_reset_out);
endmodule : lockstep_tcm_map_checker

bind lockstep_tcm_map lockstep_tcm_map_checker i_checker (.sys_clk_in, .reset_in,
  .core_zero_reset_in, .core_one_reset_in, .core_zero_req_in, .global_req_in,
  .global_is_core_in, .peripheral_guard_permit_in, .core_zero_rsp_out, .core_one_rsp_out,
  .global_rsp_out, .lockstep_out, .clamp_out, .core_zero_in_reset_out,
  .core_one_in_reset_out, .ecc_fatal_out);

//--- verif/global_master_model.sv
// Interconnect master on the global port of the TCM map block.
// Assumes requests are taken on the rising edge of clk_in.
module global_master_model (
  // Clock
  input wire logic clk_in,
  // Request and answer
  output tcm_map_pkg::req_t req_out,
  input wire tcm_map_pkg::rsp_t rsp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================================================
  // Access
  initial req_out = '0;
  // A released bus shows inverted content, so stale values never pass for data.
  task automatic do_access(input logic wr, input logic [31:0] a, input logic [31:0] d,
                           output tcm_map_pkg::rsp_t rsp);
    @(negedge clk_in);
    req_out = {1'h1, wr, a, d};
    @(posedge clk_in);
    #1 rsp = rsp_in;
    @(negedge clk_in);
    req_out = {1'h0, ~wr, ~a, ~d};
  endtask : do_access
endmodule : global_master_model

//--- verif/tb_top.sv
// Self-checking bench for the TCM map block.
// Assumes the default map and a global master model on the global port.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic clamp = 1'h0;
  logic split = 1'h1;
  logic rst0 = 1'h0;
  logic rst1 = 1'h0;
  logic is_core = 1'h0;
  logic permit = 1'h1;
  tcm_map_pkg::req_t creq [2] = '{default: '0};
  tcm_map_pkg::req_t greq;
  tcm_map_pkg::rsp_t crsp [2];
  tcm_map_pkg::rsp_t grsp;
  tcm_map_pkg::rsp_t r;
  logic lockstep, clamp_o, in_rst0, in_rst1, ecc_c, ecc_f;
  int fail_count = 0;
  int tests_run = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  lockstep_tcm_map i_lockstep_tcm_map (.sys_clk_in, .reset_in,
    .output_clamp_ctrl_in(clamp), .split_mode_select_in(split), .core_zero_reset_in(rst0),
    .core_one_reset_in(rst1), .core_zero_req_in(creq[0]), .core_one_req_in(creq[1]),
    .core_zero_rsp_out(crsp[0]), .core_one_rsp_out(crsp[1]), .global_req_in(greq),
    .global_is_core_in(is_core), .peripheral_guard_permit_in(permit), .global_rsp_out(grsp),
    .lockstep_out(lockstep), .clamp_out(clamp_o), .core_zero_in_reset_out(in_rst0),
    .core_one_in_reset_out(in_rst1), .ecc_corrected_out(ecc_c), .ecc_fatal_out(ecc_f));
  global_master_model u_master (.clk_in(sys_clk_in), .req_out(greq), .rsp_in(grsp));
  // ====================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // Port 2 is the global master; e is 0 ok, 1 refused, 2 no answer at all.
  task automatic xfer(input int p, input logic wr, input logic [31:0] a,
                      input logic [31:0] d, input logic [1:0] e, input logic [31:0] x);
    if (p == 2) u_master.do_access(wr, a, d, r);
    else begin
      @(negedge sys_clk_in);
      creq[p] = {1'h1, wr, a, d};
      @(posedge sys_clk_in);
      #1 r = crsp[p];
      @(negedge sys_clk_in);
      creq[p] = {1'h0, ~wr, ~a, ~d};
    end
    chk("valid", {31'h0, e != 2'h2}, {31'h0, r.valid});
    if (e != 2'h2) begin
      chk("error", {31'h0, e[0]}, {31'h0, r.error});
      if (!wr) chk("rdata", x, r.rdata);
    end
  endtask : xfer
  task automatic do_reset(input logic sel, input logic cl);
    @(negedge sys_clk_in);
    reset_in = 1'h1;
    split = sel;
    clamp = cl;
    repeat (5) @(negedge sys_clk_in);
    reset_in = 1'h0;
    repeat (4) @(negedge sys_clk_in);
  endtask : do_reset
  // ====================================================================
  // Scenarios
  task automatic test_split();
    do_reset(1'h1, 1'h0);
    chk("lockstep", 32'h0, {31'h0, lockstep});
    xfer(0, 1'h1, 32'h0000_0000, 32'hA5A5_0001, 2'h0, 32'h0);
    xfer(0, 1'h1, 32'h0002_FFFC, 32'hA5A5_0002, 2'h0, 32'h0);
    xfer(1, 1'h1, 32'h0000_0000, 32'h5A5A_0003, 2'h0, 32'h0);
    xfer(0, 1'h0, 32'h0000_0000, 32'h0, 2'h0, 32'hA5A5_0001);
    xfer(0, 1'h0, 32'h0001_0000, 32'h0, 2'h1, 32'h0);
    xfer(2, 1'h0, 32'hFFE0_0000, 32'h0, 2'h0, 32'hA5A5_0001);
    xfer(2, 1'h0, 32'hFFE2_FFFC, 32'h0, 2'h0, 32'hA5A5_0002);
    xfer(2, 1'h0, 32'hFFE9_0000, 32'h0, 2'h0, 32'h5A5A_0003);
    xfer(2, 1'h0, 32'hFFE8_0000, 32'h0, 2'h1, 32'h0);
    xfer(2, 1'h0, 32'hFFE4_0000, 32'h0, 2'h0, 32'h0);
    xfer(2, 1'h0, 32'hFFED_0000, 32'h0, 2'h0, 32'h0);
    permit = 1'h0;
    xfer(2, 1'h0, 32'hFFE0_0000, 32'h0, 2'h1, 32'h0);
    is_core = 1'h1;
    xfer(2, 1'h0, 32'hFFE0_0000, 32'h0, 2'h0, 32'hA5A5_0001);
    rst1 = 1'h1;
    repeat (4) @(negedge sys_clk_in);
    chk("one reset", 32'h1, {31'h0, in_rst1});
    chk("zero reset", 32'h0, {31'h0, in_rst0});
    rst1 = 1'h0;
    $display("split test done");
  endtask : test_split
  task automatic test_lock();
    do_reset(1'h0, 1'h1);
    chk("lockstep", 32'h1, {31'h0, lockstep});
    chk("clamp", 32'h1, {31'h0, clamp_o});
    xfer(0, 1'h1, 32'h0001_0000, 32'hC3C3_0004, 2'h0, 32'h0);
    xfer(0, 1'h1, 32'h0003_FFFC, 32'hC3C3_0005, 2'h0, 32'h0);
    xfer(2, 1'h0, 32'hFFE1_0000, 32'h0, 2'h0, 32'hC3C3_0004);
    xfer(2, 1'h0, 32'hFFE3_FFFC, 32'h0, 2'h0, 32'hC3C3_0005);
    xfer(2, 1'h0, 32'hFFE9_0000, 32'h0, 2'h1, 32'h0);
    xfer(2, 1'h0, 32'hFFEC_0000, 32'h0, 2'h1, 32'h0);
    // Core one's request here must go unanswered; routing interrupts to core zero is software's job.
    xfer(1, 1'h1, 32'h0000_0000, 32'h1, 2'h2, 32'h0);
    split = 1'h1;
    repeat (4) @(negedge sys_clk_in);
    chk("lockstep", 32'h1, {31'h0, lockstep});
    rst0 = 1'h1;
    repeat (4) @(negedge sys_clk_in);
    chk("one reset", 32'h1, {31'h0, in_rst1});
    rst0 = 1'h0;
    repeat (5) @(negedge sys_clk_in);
    chk("one reset", 32'h0, {31'h0, in_rst1});
    chk("fatal", 32'h0, {31'h0, ecc_f});
    chk("corrected", 32'h0, {31'h0, ecc_c});
    $display("lock-step test done");
  endtask : test_lock
  // ====================================================================
  // Sequence and watchdog
  initial begin
    test_split();
    test_lock();
    stop_test();
  end
  initial begin
    #20us;
    fail_count++;
    stop_test();
  end
endmodule : tb_top
